// file: rtl/spimsb_pkg.sv
// spimsb_pkg: constants shared by the serial port device end and its partner end
// assumes: one 100 MHz system clock on both ends, byte register port on the device end
package spimsb_pkg;

  localparam int BYTE_BITS = 8;
  localparam int ADDR_W    = 2;

  // register offsets of the device end
  localparam logic [1:0] OFF_CTRL = 2'h0;  // port_control_register
  localparam logic [1:0] OFF_STAT = 2'h1;  // port_status_register
  localparam logic [1:0] OFF_DATA = 2'h2;  // shift_data_register / receive buffer
  localparam logic [1:0] OFF_PDIR = 2'h3;  // software pin directions and select level

  // port_control_register fields
  localparam int CTL_IRQ_EN    = 7;  // transfer_irq_enable
  localparam int CTL_ENABLE    = 6;
  localparam int CTL_LSB_FIRST = 5;
  localparam int CTL_MASTER    = 4;  // master_select_bit
  localparam int CTL_RATE_HI   = 1;
  localparam int CTL_RATE_LO   = 0;

  // port_status_register fields
  localparam int STAT_DONE   = 7;  // transfer_done_flag
  localparam int STAT_WRITE_COLLISION_FLAG   = 6;  // write_collision_flag
  localparam int STAT_DOUBLE = 0;

  // pin direction register fields (one = drive) and select output level
  localparam int PDIR_MOSI     = 0;
  localparam int PDIR_SCK      = 1;
  localparam int PDIR_SS       = 2;
  localparam int PDIR_MISO     = 3;
  localparam int PDIR_SS_LEVEL = 4;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] PDIR_RST = 8'h10;

  // master clock divisors from the rate field; double speed halves them
  localparam logic [7:0] RATE_DIV0 = 8'h04;
  localparam logic [7:0] RATE_DIV1 = 8'h10;
  localparam logic [7:0] RATE_DIV2 = 8'h40;
  localparam logic [7:0] RATE_DIV3 = 8'h80;

  // sampled clock must stay longer than this many cycles in each phase
  localparam int SLV_MIN_PHASE_CYC = 2;
  // partner master half period, comfortably above the sampled minimum
  localparam int PARTNER_HALF_CYC  = 8;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOW  = 2'b01,
    ST_HIGH = 2'b11,
    ST_TAIL = 2'b10
  } spimsb_state_e;

endpackage : spimsb_pkg

// file: rtl/spimsb_link_if.sv
// spimsb_link_if: the four serial lines between device end and partner end
// assumes: each end gives value and active-low enable; undriven select and miso float high
`timescale 1ns/1ps
interface spimsb_link_if;
  logic sck;
  logic mosi;
  logic miso;
  logic ss_n;
  logic dev_sck_o, dev_sck_oe_n, dev_mosi_o, dev_mosi_oe_n;
  logic dev_miso_o, dev_miso_oe_n, dev_ss_o, dev_ss_oe_n;
  logic par_sck_o, par_sck_oe_n, par_mosi_o, par_mosi_oe_n;
  logic par_miso_o, par_miso_oe_n, par_ss_o, par_ss_oe_n;

  // wire resolution, device first; idle levels model pull resistors
  assign sck  = !dev_sck_oe_n  ? dev_sck_o  : (!par_sck_oe_n  ? par_sck_o  : 1'b0);
  assign mosi = !dev_mosi_oe_n ? dev_mosi_o : (!par_mosi_oe_n ? par_mosi_o : 1'b0);
  assign miso = !dev_miso_oe_n ? dev_miso_o : (!par_miso_oe_n ? par_miso_o : 1'b1);
  assign ss_n = !dev_ss_oe_n   ? dev_ss_o   : (!par_ss_oe_n   ? par_ss_o   : 1'b1);

  modport dev (
    input  sck, mosi, miso, ss_n,
    output dev_sck_o, dev_sck_oe_n, dev_mosi_o, dev_mosi_oe_n,
    output dev_miso_o, dev_miso_oe_n, dev_ss_o, dev_ss_oe_n
  );
  modport par (
    input  sck, mosi, miso, ss_n,
    output par_sck_o, par_sck_oe_n, par_mosi_o, par_mosi_oe_n,
    output par_miso_o, par_miso_oe_n, par_ss_o, par_ss_oe_n
  );
endinterface : spimsb_link_if

// file: rtl/spimsb_port.sv
// spimsb_port: byte serial port, master or slave, with register port and pin overrides
// assumes: link pins are asynchronous and pass two flops; clock polarity/phase fixed
// (idle low, sample on rising, change on falling)
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
// Functional notes
// - master data write starts eight-bit shift
// - after byte, clock stops, done flag set
// - done flag with enable raises interrupt
// - software drives select before master transfer
// - mosi carries master out, miso slave out
// - both preload, master clocks, contents exchange
// - master lowers select, raises after packet
// - next data write starts next byte
// - last received byte readable at data offset
// - slave idle, miso released while deselected
// - slave preload while deselected, no shifting
// - slave sets done flag after full byte
// - slave may load before reading received
// - single transmit buffer, no write mid-shift
// - receive buffer overwritten if unread
// - slave clock phases over two cycles
// - enabled port overrides pin directions
// - slave deselect resets shift logic immediately
// - master with low select input becomes slave
// - data write during transfer sets collision
// - done cleared by service or status-then-data
module spimsb_port (
  input  wire logic                           clk,
  input  wire logic                           resetn,
  input  wire logic [spimsb_pkg::ADDR_W-1:0]  addr,
  input  wire logic [7:0]                     wr_data,
  input  wire logic                           wr_en,
  input  wire logic                           rd_en,
  output logic      [7:0]                     rd_data,
  output logic                                irq,
  input  wire logic                           irq_ack,
  spimsb_link_if.dev                          link
);

  logic [7:0]                ctrl_ff, stat_ff, pdir_ff, shreg_ff, rxbuf_ff, rd_data_ff;
  logic [7:0]                div_cnt_ff, half_len, div_sel;
  logic [3:0]                sync_a_ff, sync_b_ff;
  logic                      sck_d_ff, sample_ff, busy_ff, arm_ff;
  logic [2:0]                bit_cnt_ff;
  spimsb_pkg::spimsb_state_e st_ff, nxt_st;
  logic                      en, is_master, lsb_first, sck_s, mosi_s, miso_s, ss_s;
  logic                      tick, rise, fall, byte_done, mode_fault, slave_act, deselect;
  logic                      data_wr, data_acc, busy_any, load, start, flag_clr;
  logic [7:0]                shifted;

  assign en        = ctrl_ff[spimsb_pkg::CTL_ENABLE];
  assign is_master = ctrl_ff[spimsb_pkg::CTL_MASTER];
  assign lsb_first = ctrl_ff[spimsb_pkg::CTL_LSB_FIRST];

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_a_ff <= 4'h1;
      sync_b_ff <= 4'h1;
      sck_d_ff  <= 1'b0;
    end else begin
      sync_a_ff <= {link.sck, link.mosi, link.miso, link.ss_n};
      sync_b_ff <= sync_a_ff;
      sck_d_ff  <= sync_b_ff[3];
    end
  end
  assign sck_s  = sync_b_ff[3];
  assign mosi_s = sync_b_ff[2];
  assign miso_s = sync_b_ff[1];
  assign ss_s   = sync_b_ff[0];

  // slave sees clock edges only while selected; long phases needed for sampling
  assign slave_act  = en && !is_master && !ss_s;
  assign deselect   = !is_master && ss_s;
  assign mode_fault = en && is_master && !pdir_ff[spimsb_pkg::PDIR_SS] && !ss_s;

  // divisor from rate bits, halved in double speed; counter runs half periods
  always_comb begin
    case (ctrl_ff[spimsb_pkg::CTL_RATE_HI:spimsb_pkg::CTL_RATE_LO])
      2'h0:    div_sel = spimsb_pkg::RATE_DIV0;
      2'h1:    div_sel = spimsb_pkg::RATE_DIV1;
      2'h2:    div_sel = spimsb_pkg::RATE_DIV2;
      default: div_sel = spimsb_pkg::RATE_DIV3;
    endcase
    half_len = stat_ff[spimsb_pkg::STAT_DOUBLE] ? (div_sel >> 2) : (div_sel >> 1);
  end

  assign tick = (st_ff != spimsb_pkg::ST_IDLE) && (div_cnt_ff == half_len - 8'h01);
  // sample on rising, shift on falling, for own clock or sampled clock
  assign rise = (tick && st_ff == spimsb_pkg::ST_LOW) || (slave_act && sck_s && !sck_d_ff);
  assign fall = (tick && st_ff == spimsb_pkg::ST_HIGH) || (slave_act && !sck_s && sck_d_ff);
  assign byte_done = fall && (bit_cnt_ff == 3'h7);
  assign shifted = lsb_first ? {sample_ff, shreg_ff[7:1]} : {shreg_ff[6:0], sample_ff};

  // register port decode
  assign data_wr  = wr_en && addr == spimsb_pkg::OFF_DATA;
  assign data_acc = (wr_en || rd_en) && addr == spimsb_pkg::OFF_DATA;
  assign busy_any = busy_ff || (st_ff != spimsb_pkg::ST_IDLE);
  assign load     = data_wr && !busy_any;
  assign start    = load && en && is_master && !mode_fault;
  assign flag_clr = (arm_ff && data_acc) || irq_ack;

  // master clock generator
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      spimsb_pkg::ST_IDLE: if (start) nxt_st = spimsb_pkg::ST_LOW;
      spimsb_pkg::ST_LOW:  if (tick) nxt_st = spimsb_pkg::ST_HIGH;
      spimsb_pkg::ST_HIGH: if (tick) nxt_st = byte_done ? spimsb_pkg::ST_IDLE : spimsb_pkg::ST_LOW;
      default:             nxt_st = spimsb_pkg::ST_IDLE;
    endcase
    if (mode_fault || !en || !is_master) nxt_st = spimsb_pkg::ST_IDLE;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff      <= spimsb_pkg::ST_IDLE;
      div_cnt_ff <= 8'h00;
    end else begin
      st_ff      <= nxt_st;
      div_cnt_ff <= (tick || st_ff == spimsb_pkg::ST_IDLE) ? 8'h00 : div_cnt_ff + 8'h01;
    end
  end

  // one shift register for both directions; load only when idle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shreg_ff   <= 8'h00;
      sample_ff  <= 1'b0;
      bit_cnt_ff <= 3'h0;
      busy_ff    <= 1'b0;
      rxbuf_ff   <= 8'h00;
    end else begin
      if (load) shreg_ff <= wr_data;  // slave may preload while deselected
      else if (fall) shreg_ff <= shifted;
      if (rise) sample_ff <= is_master ? miso_s : mosi_s;
      if (deselect || mode_fault || !en) begin
        bit_cnt_ff <= 3'h0;  // partial byte dropped
        busy_ff    <= 1'b0;
      end else begin
        if (fall) bit_cnt_ff <= bit_cnt_ff + 3'h1;
        if (byte_done) busy_ff <= 1'b0;
        else if (rise) busy_ff <= 1'b1;
      end
      // unread byte is overwritten by the next one
      if (byte_done) rxbuf_ff <= shifted;
    end
  end

  // control register; a mode fault drops the port to slave
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= spimsb_pkg::CTRL_RST;
      pdir_ff <= spimsb_pkg::PDIR_RST;
    end else begin
      if (wr_en && addr == spimsb_pkg::OFF_CTRL) ctrl_ff <= wr_data;
      if (mode_fault) ctrl_ff[spimsb_pkg::CTL_MASTER] <= 1'b0;
      if (wr_en && addr == spimsb_pkg::OFF_PDIR) pdir_ff <= wr_data & 8'h1F;
    end
  end

  // status flags; a set in the clearing cycle wins over the clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat_ff <= spimsb_pkg::STAT_RST;
      arm_ff  <= 1'b0;
    end else begin
      if (wr_en && addr == spimsb_pkg::OFF_STAT)
        stat_ff[spimsb_pkg::STAT_DOUBLE] <= wr_data[spimsb_pkg::STAT_DOUBLE];
      if (byte_done || mode_fault) stat_ff[spimsb_pkg::STAT_DONE] <= 1'b1;
      else if (flag_clr) stat_ff[spimsb_pkg::STAT_DONE] <= 1'b0;
      if (data_wr && busy_any) stat_ff[spimsb_pkg::STAT_WRITE_COLLISION_FLAG] <= 1'b1;
      else if (arm_ff && data_acc) stat_ff[spimsb_pkg::STAT_WRITE_COLLISION_FLAG] <= 1'b0;
      // status read with a flag up arms the clear; the data access disarms it
      if (rd_en && addr == spimsb_pkg::OFF_STAT)
        arm_ff <= stat_ff[spimsb_pkg::STAT_DONE] || stat_ff[spimsb_pkg::STAT_WRITE_COLLISION_FLAG];
      else if (data_acc || irq_ack) arm_ff <= 1'b0;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_ff <= 8'h00;
    end else if (rd_en) begin
      case (addr)
        spimsb_pkg::OFF_CTRL: rd_data_ff <= ctrl_ff;
        spimsb_pkg::OFF_STAT: rd_data_ff <= stat_ff & 8'hC1;
        spimsb_pkg::OFF_DATA: rd_data_ff <= rxbuf_ff;
        default:              rd_data_ff <= pdir_ff;
      endcase
    end else begin
      rd_data_ff <= 8'h00;
    end
  end
  assign rd_data = rd_data_ff;
  assign irq = stat_ff[spimsb_pkg::STAT_DONE] && ctrl_ff[spimsb_pkg::CTL_IRQ_EN];

  // pin drivers; disabled port releases all four lines
  // select is never driven by the shifter, only by its software level
  assign link.dev_sck_o    = (st_ff == spimsb_pkg::ST_HIGH);
  assign link.dev_mosi_o   = lsb_first ? shreg_ff[0] : shreg_ff[7];
  assign link.dev_miso_o   = lsb_first ? shreg_ff[0] : shreg_ff[7];
  assign link.dev_ss_o     = pdir_ff[spimsb_pkg::PDIR_SS_LEVEL];
  assign link.dev_sck_oe_n  = !(en && is_master && pdir_ff[spimsb_pkg::PDIR_SCK]);
  assign link.dev_mosi_oe_n = !(en && is_master && pdir_ff[spimsb_pkg::PDIR_MOSI]);
  assign link.dev_ss_oe_n   = !(en && is_master && pdir_ff[spimsb_pkg::PDIR_SS]);
  // master forces miso to input; deselected slave keeps it released
  assign link.dev_miso_oe_n = !(slave_act && pdir_ff[spimsb_pkg::PDIR_MISO]);

endmodule : spimsb_port

// file: rtl/spimsb_partner.sv
// spimsb_partner: far end of the serial link, one byte per request, master or slave role
// assumes: most significant bit first, clock idle low, sample rising, change falling
`timescale 1ns/1ps
module spimsb_partner #(
  parameter int HALF_CYC = spimsb_pkg::PARTNER_HALF_CYC
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       act_as_master,
  input  wire logic [7:0] tx_byte,
  input  wire logic       start,
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  output logic            busy,
  spimsb_link_if.par      link
);

  logic [3:0]                sync_a_ff, sync_b_ff;
  logic                      sck_d_ff, sample_ff, rx_valid_ff, sel_ff;
  logic [7:0]                sh_ff, rx_ff, cnt_ff;
  logic [2:0]                bit_cnt_ff;
  spimsb_pkg::spimsb_state_e st_ff, nxt_st;
  logic                      tick, rise, fall, done, slv_act, load;

  // pin synchronisers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync_a_ff <= 4'h1;
      sync_b_ff <= 4'h1;
      sck_d_ff  <= 1'b0;
    end else begin
      sync_a_ff <= {link.sck, link.mosi, link.miso, link.ss_n};
      sync_b_ff <= sync_a_ff;
      sck_d_ff  <= sync_b_ff[3];
    end
  end

  assign slv_act = !act_as_master && !sync_b_ff[0];
  assign tick = (st_ff != spimsb_pkg::ST_IDLE) && (cnt_ff == 8'(HALF_CYC - 1));
  assign rise = (tick && st_ff == spimsb_pkg::ST_LOW) || (slv_act && sync_b_ff[3] && !sck_d_ff);
  assign fall = (tick && st_ff == spimsb_pkg::ST_HIGH) || (slv_act && !sync_b_ff[3] && sck_d_ff);
  assign done = fall && bit_cnt_ff == 3'h7;
  assign busy = (st_ff != spimsb_pkg::ST_IDLE) || (bit_cnt_ff != 3'h0) || sel_ff;
  assign load = start && !busy;

  // master role: select low, eight clocks, a tail half period, select high
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      spimsb_pkg::ST_IDLE: if (load && act_as_master) nxt_st = spimsb_pkg::ST_LOW;
      spimsb_pkg::ST_LOW:  if (tick) nxt_st = spimsb_pkg::ST_HIGH;
      spimsb_pkg::ST_HIGH: if (tick) nxt_st = done ? spimsb_pkg::ST_TAIL : spimsb_pkg::ST_LOW;
      spimsb_pkg::ST_TAIL: if (tick) nxt_st = spimsb_pkg::ST_IDLE;
      default:             nxt_st = spimsb_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff  <= spimsb_pkg::ST_IDLE;
      cnt_ff <= 8'h00;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= (tick || st_ff == spimsb_pkg::ST_IDLE) ? 8'h00 : cnt_ff + 8'h01;
    end
  end

  // shift and receive; slave role drops partial byte on deselect
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sh_ff       <= 8'h00;
      sample_ff   <= 1'b0;
      bit_cnt_ff  <= 3'h0;
      rx_ff       <= 8'h00;
      rx_valid_ff <= 1'b0;
      sel_ff      <= 1'b0;
    end else begin
      rx_valid_ff <= done;
      sel_ff      <= slv_act;
      if (load) sh_ff <= tx_byte;  // preload before clocks
      else if (fall) sh_ff <= {sh_ff[6:0], sample_ff};
      if (rise) sample_ff <= act_as_master ? sync_b_ff[1] : sync_b_ff[2];
      if (!act_as_master && sync_b_ff[0]) bit_cnt_ff <= 3'h0;
      else if (fall) bit_cnt_ff <= bit_cnt_ff + 3'h1;
      if (done) rx_ff <= {sh_ff[6:0], sample_ff};
    end
  end
  assign rx_byte  = rx_ff;
  assign rx_valid = rx_valid_ff;

  // role decides which lines this end drives
  assign link.par_sck_o     = (st_ff == spimsb_pkg::ST_HIGH);
  assign link.par_mosi_o    = sh_ff[7];
  assign link.par_miso_o    = sh_ff[7];
  assign link.par_ss_o      = (st_ff == spimsb_pkg::ST_IDLE);
  assign link.par_sck_oe_n  = !act_as_master;
  assign link.par_mosi_oe_n = !act_as_master;
  assign link.par_ss_oe_n   = !act_as_master;
  assign link.par_miso_oe_n = !slv_act;

endmodule : spimsb_partner

// file: sim/spimsb_asserts.sv
// spimsb_asserts: checks on the serial lines between the two ends
// assumes: placed beside the link interface, one clock domain, mode 0 timing
`timescale 1ns/1ps
module spimsb_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic ss_n,
  input wire logic dev_sck_oe_n,
  input wire logic dev_mosi_oe_n,
  input wire logic dev_miso_oe_n,
  input wire logic dev_ss_oe_n,
  input wire logic par_sck_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  logic       sck_q_ff;
  logic [3:0] rise_cnt_ff;

  // rising clock edges inside one select window, cleared while deselected
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_q_ff    <= 1'b0;
      rise_cnt_ff <= 4'h0;
    end else begin
      sck_q_ff <= sck;
      if (ss_n) rise_cnt_ff <= 4'h0;
      else if (sck && !sck_q_ff) rise_cnt_ff <= rise_cnt_ff + 4'h1;
    end
  end

  a_master_miso_in: assert property (!dev_sck_oe_n |-> dev_miso_oe_n)
    else $error("miso driven while this end drives the clock");
  a_slave_inputs: assert property (
    !dev_miso_oe_n |-> dev_sck_oe_n && dev_mosi_oe_n && dev_ss_oe_n)
    else $error("slave drives a line other than miso");
  // sync stages delay the release by a few cycles
  a_slave_quiet: assert property ((dev_sck_oe_n && ss_n)[*5] |-> dev_miso_oe_n)
    else $error("miso still driven while deselected");
  a_byte_count: assert property ($rose(ss_n) |-> rise_cnt_ff[2:0] == 3'h0)
    else $error("packet ended on a partial byte");
  a_data_stable: assert property (
    !ss_n && sck && $past(sck) |-> $stable(mosi) && (dev_miso_oe_n || $stable(miso)))
    else $error("data line moved while clock high");
  a_phase_high: assert property (!par_sck_oe_n && $rose(sck) |-> sck[*3])
    else $error("far clock high phase too short");
  a_phase_low: assert property (!par_sck_oe_n && !ss_n && $fell(sck) |-> (!sck)[*3])
    else $error("far clock low phase too short");
  a_idle_clock: assert property (ss_n |-> !sck)
    else $error("clock high while deselected");
  a_select_first: assert property ($fell(ss_n) |-> (!sck)[*2])
    else $error("clock moved right at select");
endmodule : spimsb_asserts

// file: sim/tb_top.sv
// tb_top: drives the device end through its register port against the far end
// assumes: both ends share clk; link interface joins them; checker sits beside it
`timescale 1ns/1ps
module tb_top;
  logic                          clk;
  logic                          resetn;
  logic [spimsb_pkg::ADDR_W-1:0] addr;
  logic [7:0]                    wr_data;
  logic                          wr_en;
  logic                          rd_en;
  logic [7:0]                    rd_data;
  logic                          irq;
  logic                          irq_ack;
  logic                          act_as_master;
  logic [7:0]                    tx_byte;
  logic                          start;
  logic [7:0]                    rx_byte;
  logic                          rx_valid;
  logic                          busy;
  int                            n_errors;
  int                            n_compared;

  spimsb_link_if link ();
  spimsb_port spimsb_port_i (.clk(clk), .resetn(resetn), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .irq_ack(irq_ack), .link(link));
  spimsb_partner #(.HALF_CYC(spimsb_pkg::PARTNER_HALF_CYC)) spimsb_partner_i (.clk(clk),
    .resetn(resetn), .act_as_master(act_as_master), .tx_byte(tx_byte), .start(start),
    .rx_byte(rx_byte), .rx_valid(rx_valid), .busy(busy), .link(link));
  spimsb_asserts spimsb_asserts_i (.clk(clk), .resetn(resetn), .sck(link.sck),
    .mosi(link.mosi), .miso(link.miso), .ss_n(link.ss_n), .dev_sck_oe_n(link.dev_sck_oe_n),
    .dev_mosi_oe_n(link.dev_mosi_oe_n), .dev_miso_oe_n(link.dev_miso_oe_n),
    .dev_ss_oe_n(link.dev_ss_oe_n), .par_sck_oe_n(link.par_sck_oe_n));

  // free-running system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wrap_up();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got 0x%h expected 0x%h", $time, got, exp);
    end
  endtask : chk

  // one-cycle strobes; an idle cycle between calls keeps each strobe single-driven
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rd_data, exp);
  endtask : rd

  task automatic pulse_start(input logic [7:0] b);
    @(posedge clk);
    tx_byte <= b;
    start   <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    #1;
    chk({7'h00, busy}, {7'h00, act_as_master});
  endtask : pulse_start

  // bounded wait on irq level or the far end's byte pulse
  task automatic wait_on(input logic sel);
    int k;
    k = 0;
    while ((sel ? irq : rx_valid) !== 1'b1 && k < 4000) begin
      @(negedge clk);
      k++;
    end
    // a limit that runs out is a failure, not a silent fall-through
    if ((sel ? irq : rx_valid) !== 1'b1) begin
      n_errors++;
      $display("wait limit reached at %0t", $time);
    end
  endtask : wait_on

  task automatic t_regs();
    rd(spimsb_pkg::OFF_CTRL, 8'h00);
    rd(spimsb_pkg::OFF_STAT, 8'h00);
    rd(spimsb_pkg::OFF_PDIR, 8'h10);
    chk({4'h0, link.dev_sck_oe_n, link.dev_mosi_oe_n, link.dev_miso_oe_n,
         link.dev_ss_oe_n}, 8'h0F);
    wr(spimsb_pkg::OFF_STAT, 8'hFF);
    rd(spimsb_pkg::OFF_STAT, 8'h01);
    wr(spimsb_pkg::OFF_PDIR, 8'hFF);
    rd(spimsb_pkg::OFF_PDIR, 8'h1F);
    wr(spimsb_pkg::OFF_CTRL, 8'hD1);
    rd(spimsb_pkg::OFF_CTRL, 8'hD1);
  endtask : t_regs

  // one master byte; miso drive is requested but must stay overridden
  task automatic t_master(input logic dbl, input logic coll, input logic [7:0] dv,
                          input logic [7:0] pv);
    int w;
    wr(spimsb_pkg::OFF_STAT, {7'h00, dbl});
    pulse_start(pv);
    wr(spimsb_pkg::OFF_PDIR, 8'h0F);
    wr(spimsb_pkg::OFF_DATA, dv);
    while (link.sck !== 1'b1) @(negedge clk);
    w = 0;
    while (link.sck === 1'b1) begin
      @(negedge clk);
      w++;
    end
    chk(8'(w), dbl ? 8'h04 : 8'h08);
    if (coll) wr(spimsb_pkg::OFF_DATA, 8'hFF);
    wait_on(1'b0);
    chk(rx_byte, dv);
    wait_on(1'b1);
    chk({7'h00, irq}, 8'h01);
    wr(spimsb_pkg::OFF_PDIR, 8'h1F);
    if (coll) begin
      rd(spimsb_pkg::OFF_STAT, 8'hC0);
      rd(spimsb_pkg::OFF_DATA, pv);
      rd(spimsb_pkg::OFF_STAT, 8'h00);
    end else begin
      @(posedge clk);
      irq_ack <= 1'b1;
      @(posedge clk);
      irq_ack <= 1'b0;
      #1;
      chk({7'h00, irq}, 8'h00);
      rd(spimsb_pkg::OFF_STAT, 8'h01);
    end
  endtask : t_master

  // master sending least significant bit first to a far end that takes msb first
  task automatic t_lsb();
    wr(spimsb_pkg::OFF_CTRL, 8'hF1);
    pulse_start(8'h00);
    wr(spimsb_pkg::OFF_PDIR, 8'h0F);
    wr(spimsb_pkg::OFF_DATA, 8'h01);
    wait_on(1'b0);
    chk(rx_byte, 8'h80);
    wait_on(1'b1);
    wr(spimsb_pkg::OFF_PDIR, 8'h1F);
    @(posedge clk);
    irq_ack <= 1'b1;
    @(posedge clk);
    irq_ack <= 1'b0;
  endtask : t_lsb

  // slave: preload while deselected, reload before reading, unread byte overwritten
  task automatic t_slave();
    wr(spimsb_pkg::OFF_STAT, 8'h00);
    wr(spimsb_pkg::OFF_CTRL, 8'hC0);
    wr(spimsb_pkg::OFF_PDIR, 8'h08);
    act_as_master <= 1'b1;
    wr(spimsb_pkg::OFF_DATA, 8'hC3);
    repeat (8) @(negedge clk);
    chk({7'h00, link.dev_miso_oe_n}, 8'h01);
    rd(spimsb_pkg::OFF_STAT, 8'h00);
    pulse_start(8'h69);
    wait_on(1'b0);
    chk(rx_byte, 8'hC3);
    wait_on(1'b1);
    rd(spimsb_pkg::OFF_STAT, 8'h80);
    wr(spimsb_pkg::OFF_DATA, 8'h5E);
    pulse_start(8'h33);
    wait_on(1'b0);
    chk(rx_byte, 8'h5E);
    wait_on(1'b1);
    rd(spimsb_pkg::OFF_STAT, 8'h80);
    rd(spimsb_pkg::OFF_DATA, 8'h33);
  endtask : t_slave

  // master with select as input gets selected by the far master
  task automatic t_fault();
    wr(spimsb_pkg::OFF_PDIR, 8'h03);
    wr(spimsb_pkg::OFF_CTRL, 8'hD1);
    pulse_start(8'h0F);
    wait_on(1'b0);
    rd(spimsb_pkg::OFF_CTRL, 8'hC1);
    rd(spimsb_pkg::OFF_STAT, 8'h80);
  endtask : t_fault

  // main sequence
  initial begin
    resetn        = 1'b0;
    addr          = 2'h0;
    wr_data       = 8'h00;
    wr_en         = 1'b0;
    rd_en         = 1'b0;
    irq_ack       = 1'b0;
    act_as_master = 1'b0;
    tx_byte       = 8'h00;
    start         = 1'b0;
    n_errors      = 0;
    n_compared    = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_master(1'b0, 1'b1, 8'hA5, 8'h3C);
    t_master(1'b1, 1'b0, 8'h4B, 8'hD2);
    t_lsb();
    t_slave();
    t_fault();
    wrap_up();
  end

  // watchdog, well beyond the thousand or so cycles the tests need
  initial begin
    #400000;
    n_errors++;
    $display("watchdog expired at %0t", $time);
    wrap_up();
  end
endmodule : tb_top
